// *** temp_flags_pkg.sv ***
// constants shared by the threshold status-flag block and its helpers
// assumes 8-bit two's complement temperatures in whole degrees celsius
package temp_flags_pkg;

   // channel numbering: 0..5 are remote channels 1..6, 6 is the local sensor
   localparam int NCH = 7;
   localparam int NREM = 6;
   localparam int CH_W = 3;
   localparam int TEMP_W = 8;
   localparam logic [2:0] LOCAL_CH = 3'h6;
   localparam logic [2:0] LAST_CH = 3'h6;
   localparam logic [2:0] FIRST_CH = 3'h0;

   // high-alert flags: bit n is channel n, bit 6 local, bit 7 reserved
   localparam logic [7:0] ALERT_BITS = 8'h7f;
   // overtemp flags: remote 1, 4, 5 and 6 at bits 0, 3, 4, 5
   localparam logic [7:0] OT_BITS = 8'h39;

   // reset values
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [2:0] CH_RST = 3'h0;

   // hysteresis for releasing a fault condition, in degrees
   localparam int HYST_DEG = 4;
   localparam logic signed [8:0] HYST_C = 9'(HYST_DEG);

   // sequencer states
   typedef enum logic [1:0] {SEQ_PICK, SEQ_START, SEQ_WAIT} seq_state_t;

   // measured temperature strictly above the limit
   function automatic logic temp_above(input logic [7:0] t, input logic [7:0] l);
      temp_above = $signed(t) > $signed(l);
   endfunction : temp_above

   // measured temperature below the limit minus the hysteresis
   function automatic logic temp_released(input logic [7:0] t, input logic [7:0] l);
      logic signed [8:0] lim;
      lim = $signed({l[7], l}) - HYST_C;
      temp_released = $signed({t[7], t}) < lim;
   endfunction : temp_released

endpackage : temp_flags_pkg

// *** flag_sync.sv ***
// two-stage synchroniser for the diode fault detector levels
// assumes slow static levels; no pulse is expected to survive crossing
`timescale 1ns/1ns
`default_nettype none
module flag_sync
   import temp_flags_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // levels
   input wire logic [NREM-1:0] din,
   output logic [NREM-1:0] dout
);

   logic [NREM-1:0] meta_reg;
   logic [NREM-1:0] meta_next;
   logic [NREM-1:0] sync_reg;
   logic [NREM-1:0] sync_next;

   // first stage feeds only the second
   always_comb
   begin
      meta_next = din;
      sync_next = meta_reg;
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign dout = sync_reg;

endmodule : flag_sync
`default_nettype wire

// *** chan_hyst.sv ***
// per-channel alert and overtemperature conditions with release hysteresis
// assumes upd pulses once per finished conversion of this channel
`timescale 1ns/1ns
`default_nettype none
module chan_hyst
   import temp_flags_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // new result
   input wire logic upd,
   input wire logic [TEMP_W-1:0] temp,
   // limits
   input wire logic [TEMP_W-1:0] alert_limit,
   input wire logic [TEMP_W-1:0] ot_limit,
   // conditions
   output logic alert_cond,
   output logic ot_cond
);

   logic alert_reg;
   logic alert_next;
   logic ot_reg;
   logic ot_next;

   // set above the limit, clear only below limit minus hysteresis
   always_comb
   begin
      alert_next = alert_reg;
      ot_next = ot_reg;
      if (upd)
      begin
         if (temp_above(temp, alert_limit))
            alert_next = 1'b1;
         else if (temp_released(temp, alert_limit))
            alert_next = 1'b0;
         if (temp_above(temp, ot_limit))
            ot_next = 1'b1;
         else if (temp_released(temp, ot_limit))
            ot_next = 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         alert_reg <= 1'b0;
         ot_reg <= 1'b0;
      end
      else
      begin
         alert_reg <= alert_next;
         ot_reg <= ot_next;
      end
   end

   assign alert_cond = alert_reg;
   assign ot_cond = ot_reg;

endmodule : chan_hyst
`default_nettype wire

// *** temp_threshold_status_flags.sv ***
// threshold status flags, measurement sequencer and alert/overheat pins
// assumes a conversion engine on mclk and a serial slave issuing read strobes
//
// Operation
// - local channel above its high-alert limit sets high-alert bit 6
// - remote 1 above its high-alert limit sets high-alert bit 0
// - remote 2 above its high-alert limit sets high-alert bit 1
// - remote 3 above its high-alert limit sets high-alert bit 2
// - remote 4 above its high-alert limit sets high-alert bit 3
// - remote 5 above its high-alert limit sets high-alert bit 4
// - remote 6 above its high-alert limit sets high-alert bit 5
// - remote 1 above its overtemp limit sets overtemp bit 0
// - remote 4 above its overtemp limit sets overtemp bit 3
// - remote 5 above its overtemp limit sets overtemp bit 4
// - remote 6 above its overtemp limit sets overtemp bit 5
// - open or supply-tied diode is flagged and skipped by the sequencer
// - a masked channel cannot assert the alert or overheat output
// - overtemp bits clear only on its read; the read leaves the output alone
// - a persisting alert reasserts after the next finished conversion
// - a condition is removed only below limit minus four degrees
// - alert mask bit one suppresses that channel; masks reset to zero
`timescale 1ns/1ns
`default_nettype none
module temp_threshold_status_flags
   import temp_flags_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // conversion engine
   output logic conv_start,
   output logic [CH_W-1:0] conv_channel,
   input wire logic result_valid,
   input wire logic [TEMP_W-1:0] result_temp,
   // limits, index is the channel number
   input wire logic [NCH-1:0][TEMP_W-1:0] alert_limit_vec,
   input wire logic [NCH-1:0][TEMP_W-1:0] ot_limit_vec,
   // diode fault detectors, asynchronous levels
   input wire logic [NREM-1:0] diode_open,
   input wire logic [NREM-1:0] diode_at_supply,
   // register read port
   input wire logic rd_status1,
   input wire logic rd_status2,
   output logic [7:0] rd_data,
   output logic rd_valid,
   // mask write port
   input wire logic alert_mask_wr,
   input wire logic overheat_mask_wr,
   input wire logic [7:0] mask_wdata,
   output logic [7:0] alert_mask_q,
   output logic [7:0] overheat_mask_q,
   // status
   output logic [7:0] high_alert_flags,
   output logic [7:0] overtemp_flags,
   output logic [NREM-1:0] diode_fault,
   // open-drain pins, enable high pulls the pin low
   output logic alert_output_oe,
   output logic overheat_shutdown_output_oe
);

   logic [NREM-1:0] open_s;
   logic [NREM-1:0] supply_s;
   logic [NCH-1:0] alert_cond;
   logic [NCH-1:0] ot_cond;

   seq_state_t state_reg;
   seq_state_t state_next;
   logic [CH_W-1:0] chan_reg;
   logic [CH_W-1:0] chan_next;
   logic start_reg;
   logic start_next;
   logic [NCH-1:0] upd_reg;
   logic [NCH-1:0] upd_next;
   logic [NCH-1:0] done_reg;
   logic [NCH-1:0] done_next;

   logic [NREM-1:0] fault_reg;
   logic [NREM-1:0] fault_next;
   logic [7:0] amask_reg;
   logic [7:0] amask_next;
   logic [7:0] omask_reg;
   logic [7:0] omask_next;
   logic [7:0] st1_reg;
   logic [7:0] st1_next;
   logic [7:0] st2_reg;
   logic [7:0] st2_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic rvalid_reg;
   logic rvalid_next;
   logic alert_reg;
   logic alert_next;
   logic ovh_reg;
   logic ovh_next;
   logic [7:0] st1_set;
   logic [7:0] st2_set;

   // diode detector levels come from the analog side
   flag_sync u_open_sync
   (
      .mclk (mclk),
      .rst (rst),
      .din (diode_open),
      .dout (open_s)
   );

   flag_sync u_supply_sync
   (
      .mclk (mclk),
      .rst (rst),
      .din (diode_at_supply),
      .dout (supply_s)
   );

   // one condition tracker per channel
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++)
      begin : g_chan
         chan_hyst u_hyst
         (
            .mclk (mclk),
            .rst (rst),
            .upd (upd_reg[gi]),
            .temp (result_temp),
            .alert_limit (alert_limit_vec[gi]),
            .ot_limit (ot_limit_vec[gi]),
            .alert_cond (alert_cond[gi]),
            .ot_cond (ot_cond[gi])
         );
      end
   endgenerate

   // true when the given channel is a remote one with a faulty diode
   function automatic logic chan_skipped(input logic [CH_W-1:0] ch,
                                         input logic [NREM-1:0] flt);
      chan_skipped = (ch != LOCAL_CH) && flt[ch];
   endfunction : chan_skipped

   // measurement sequencer; the temperature is latched into the tracker
   // one cycle after result_valid, so result_temp must hold for that cycle
   always_comb
   begin
      state_next = state_reg;
      chan_next = chan_reg;
      start_next = 1'b0;
      upd_next = '0;
      case (state_reg)
         SEQ_PICK:
         begin
            if (chan_skipped(chan_reg, fault_reg))
               chan_next = (chan_reg == LAST_CH) ? FIRST_CH : chan_reg + 3'h1;
            else
            begin
               start_next = 1'b1;
               state_next = SEQ_START;
            end
         end
         SEQ_START:
            state_next = SEQ_WAIT;
         SEQ_WAIT:
         begin
            if (result_valid)
            begin
               upd_next[chan_reg] = 1'b1;
               chan_next = (chan_reg == LAST_CH) ? FIRST_CH : chan_reg + 3'h1;
               state_next = SEQ_PICK;
            end
         end
         default:
            state_next = SEQ_PICK;
      endcase
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         state_reg <= SEQ_PICK;
         chan_reg <= CH_RST;
         start_reg <= 1'b0;
         upd_reg <= '0;
         done_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         chan_reg <= chan_next;
         start_reg <= start_next;
         upd_reg <= upd_next;
         done_reg <= done_next;
      end
   end

   // done marks the first cycle in which the tracker holds the fresh condition
   always_comb
   begin
      done_next = upd_reg;
   end

   // fault flags follow the detectors live; a repaired diode rejoins
   always_comb
   begin
      fault_next = open_s | supply_s;
   end

   // masks: only defined bits are writable, reserved bits stay zero
   always_comb
   begin
      amask_next = amask_reg;
      omask_next = omask_reg;
      if (alert_mask_wr)
         amask_next = mask_wdata & ALERT_BITS;
      if (overheat_mask_wr)
         omask_next = mask_wdata & OT_BITS;
   end

   // status bits are set only at a finished conversion of their channel
   always_comb
   begin
      st1_set = '0;
      st2_set = '0;
      for (int i = 0; i < NCH; i++)
      begin
         st1_set[i] = done_reg[i] & alert_cond[i];
         st2_set[i] = done_reg[i] & ot_cond[i] & OT_BITS[i];
      end
   end

   // sticky flags; a set in the same cycle as the read wins over the clear
   always_comb
   begin
      st1_next = st1_reg;
      st2_next = st2_reg;
      rdata_next = rdata_reg;
      rvalid_next = 1'b0;
      if (rd_status1)
      begin
         st1_next = FLAGS_RST;
         rdata_next = st1_reg & ALERT_BITS;
         rvalid_next = 1'b1;
      end
      else if (rd_status2)
      begin
         st2_next = FLAGS_RST;
         rdata_next = st2_reg & OT_BITS;
         rvalid_next = 1'b1;
      end
      st1_next = (st1_next | st1_set) & ALERT_BITS;
      st2_next = (st2_next | st2_set) & OT_BITS;
   end

   // pins: alert follows the sticky flags, so a read drops it until the
   // next conversion; overheat follows the live condition, not the flags
   always_comb
   begin
      alert_next = |(st1_reg & ~amask_reg & ALERT_BITS);
      ovh_next = |({1'b0, ot_cond} & ~omask_reg & OT_BITS);
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         fault_reg <= '0;
         amask_reg <= MASK_RST;
         omask_reg <= MASK_RST;
         st1_reg <= FLAGS_RST;
         st2_reg <= FLAGS_RST;
         rdata_reg <= FLAGS_RST;
         rvalid_reg <= 1'b0;
         alert_reg <= 1'b0;
         ovh_reg <= 1'b0;
      end
      else
      begin
         fault_reg <= fault_next;
         amask_reg <= amask_next;
         omask_reg <= omask_next;
         st1_reg <= st1_next;
         st2_reg <= st2_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
         alert_reg <= alert_next;
         ovh_reg <= ovh_next;
      end
   end

   // every output comes straight from a flip-flop
   assign conv_start = start_reg;
   assign conv_channel = chan_reg;
   assign rd_data = rdata_reg;
   assign rd_valid = rvalid_reg;
   assign alert_mask_q = amask_reg;
   assign overheat_mask_q = omask_reg;
   assign high_alert_flags = st1_reg;
   assign overtemp_flags = st2_reg;
   assign diode_fault = fault_reg;
   assign alert_output_oe = alert_reg;
   assign overheat_shutdown_output_oe = ovh_reg;

endmodule : temp_threshold_status_flags
`default_nettype wire

// *** temp_flags_properties.sv ***
// concurrent checks on the ports of the threshold status-flag block
// assumes one clock domain on mclk with asynchronous active-high rst
`timescale 1ns/1ns
`default_nettype none
module temp_flags_checker
   import temp_flags_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // strobes
   input wire logic conv_start,
   input wire logic result_valid,
   input wire logic rd_status1,
   input wire logic rd_status2,
   input wire logic overheat_mask_wr,
   // observed state
   input wire logic [7:0] rd_data,
   input wire logic rd_valid,
   input wire logic [7:0] alert_mask_q,
   input wire logic [7:0] high_alert_flags,
   input wire logic [7:0] overtemp_flags,
   input wire logic alert_output_oe,
   input wire logic overheat_shutdown_output_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);

   // unmasked alert demand, the pin follows it one cycle later
   logic alert_any;
   assign alert_any = |(high_alert_flags & ~alert_mask_q);

   // read port answers one cycle after the strobe with pre-clear flags
   a_rd_valid_answer: assert property ((rd_status1 || rd_status2) |=> rd_valid)
      else $error("read strobe without answer");
   a_s1_read_data: assert property (rd_status1 |=> rd_data == ($past(high_alert_flags) & 8'h7f))
      else $error("high-alert read data wrong");
   a_s2_read_data: assert property (rd_status2 && !rd_status1 |=>
      rd_data == ($past(overtemp_flags) & OT_BITS))
      else $error("overtemp read data wrong");
   a_reserved_bits_zero: assert property (
      ((high_alert_flags & ~ALERT_BITS) == 8'h00) && ((overtemp_flags & ~OT_BITS) == 8'h00))
      else $error("reserved status bit set");
   a_alert_pin_follows: assert property (1'b1 |=> alert_output_oe == $past(alert_any))
      else $error("alert pin does not follow unmasked flags");
   // reads never release the overheat pin: only a result or a mask write can
   a_ot_pin_holds: assert property ($fell(overheat_shutdown_output_oe) |->
      $past(result_valid, 2) || $past(result_valid, 3) || $past(result_valid, 4) ||
      $past(result_valid, 5) || $past(overheat_mask_wr) || $past(overheat_mask_wr, 2) ||
      $past(overheat_mask_wr, 3))
      else $error("overheat pin fell without cause");
   // a flag only rises after a finished conversion
   a_alert_set_cause: assert property (
      (high_alert_flags & ~$past(high_alert_flags)) != 8'h00 |->
      $past(result_valid, 2) || $past(result_valid, 3) || $past(result_valid, 4))
      else $error("high-alert flag set without result");
   a_ot_set_cause: assert property (
      (overtemp_flags & ~$past(overtemp_flags)) != 8'h00 |->
      $past(result_valid, 2) || $past(result_valid, 3) || $past(result_valid, 4))
      else $error("overtemp flag set without result");
   a_conv_one_cycle: assert property (conv_start |=> !conv_start)
      else $error("conversion request longer than one cycle");
endmodule : temp_flags_checker

bind temp_threshold_status_flags temp_flags_checker u_chk (.mclk(mclk), .rst(rst),
   .conv_start(conv_start), .result_valid(result_valid), .rd_status1(rd_status1),
   .rd_status2(rd_status2), .overheat_mask_wr(overheat_mask_wr), .rd_data(rd_data),
   .rd_valid(rd_valid), .alert_mask_q(alert_mask_q), .high_alert_flags(high_alert_flags),
   .overtemp_flags(overtemp_flags), .alert_output_oe(alert_output_oe),
   .overheat_shutdown_output_oe(overheat_shutdown_output_oe));
`default_nettype wire

// *** conv_engine_model.sv ***
// behavioural conversion engine answering the block's requests
// assumes the bench sets per-channel temperatures and the answer delay
`timescale 1ns/1ns
`default_nettype none
module conv_engine_model
   import temp_flags_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // request
   input wire logic conv_start,
   input wire logic [CH_W-1:0] conv_channel,
   // stimulus
   input wire logic [NCH-1:0][TEMP_W-1:0] temps,
   input wire logic [3:0] delay,
   // answer
   output logic result_valid,
   output logic [TEMP_W-1:0] result_temp
);
   logic busy;
   logic [3:0] cnt;

   // result held for its pulse and one cycle more, then scrambled so no stale value is read
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         busy <= 1'b0;
         cnt <= 4'h0;
         result_valid <= 1'b0;
         result_temp <= 8'h00;
      end
      else
      begin
         result_valid <= 1'b0;
         if (conv_start)
         begin
            busy <= 1'b1;
            cnt <= delay;
         end
         else if (busy && cnt == 4'h0)
         begin
            busy <= 1'b0;
            result_valid <= 1'b1;
            result_temp <= temps[conv_channel];
         end
         else
         begin
            if (busy)
               cnt <= cnt - 4'h1;
            if (!result_valid)
               result_temp <= ~result_temp;
         end
      end
   end
endmodule : conv_engine_model
`default_nettype wire

// *** temp_threshold_status_flags_tb.sv ***
// self-checking bench for the threshold status-flag block
// assumes the engine model answers every request; limits 50 alert, 60 overtemp
`timescale 1ns/1ns
`default_nettype none
module temp_threshold_status_flags_tb
   import temp_flags_pkg::*;
;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic conv_start, result_valid, rd_valid, alert_output_oe, overheat_shutdown_output_oe;
   logic [2:0] conv_channel;
   logic [7:0] result_temp, rd_data, alert_mask_q, overheat_mask_q, high_alert_flags;
   logic [7:0] overtemp_flags;
   logic [NREM-1:0] diode_fault;
   logic [NREM-1:0] diode_open = '0;
   logic [NREM-1:0] diode_at_supply = '0;
   logic rd_status1 = 1'b0;
   logic rd_status2 = 1'b0;
   logic alert_mask_wr = 1'b0;
   logic overheat_mask_wr = 1'b0;
   logic [7:0] mask_wdata = 8'h00;
   logic [NCH-1:0][TEMP_W-1:0] alert_limit_vec = {NCH{8'h32}};
   logic [NCH-1:0][TEMP_W-1:0] ot_limit_vec = {NCH{8'h3c}};
   logic [NCH-1:0][TEMP_W-1:0] temps = {NCH{8'h14}};
   logic [NCH-1:0][TEMP_W-1:0] t;
   logic [3:0] delay = 4'h3;
   int num_errors = 0;
   int total_checks = 0;
   int bad;

   temp_threshold_status_flags DUT (.mclk(mclk), .rst(rst), .conv_start(conv_start),
      .conv_channel(conv_channel), .result_valid(result_valid), .result_temp(result_temp),
      .alert_limit_vec(alert_limit_vec), .ot_limit_vec(ot_limit_vec),
      .diode_open(diode_open), .diode_at_supply(diode_at_supply), .rd_status1(rd_status1),
      .rd_status2(rd_status2), .rd_data(rd_data), .rd_valid(rd_valid),
      .alert_mask_wr(alert_mask_wr), .overheat_mask_wr(overheat_mask_wr),
      .mask_wdata(mask_wdata), .alert_mask_q(alert_mask_q), .overheat_mask_q(overheat_mask_q),
      .high_alert_flags(high_alert_flags), .overtemp_flags(overtemp_flags),
      .diode_fault(diode_fault), .alert_output_oe(alert_output_oe),
      .overheat_shutdown_output_oe(overheat_shutdown_output_oe));

   conv_engine_model engine (.mclk(mclk), .rst(rst), .conv_start(conv_start),
      .conv_channel(conv_channel), .temps(temps), .delay(delay),
      .result_valid(result_valid), .result_temp(result_temp));

   // 25 MHz clock
   always #20 mclk = ~mclk;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one read strobe; the answer stands in the cycle after it is taken
   task automatic rd(input logic two, input logic [7:0] exp, input logic en);
      @(posedge mclk);
      rd_status1 <= ~two;
      rd_status2 <= two;
      @(posedge mclk);
      rd_status1 <= 1'b0;
      rd_status2 <= 1'b0;
      #1;
      if (en)
      begin
         chk({7'h00, rd_valid}, 8'h01);
         chk(rd_data, exp);
      end
   endtask : rd

   task automatic wm(input logic ot, input logic [7:0] v);
      @(posedge mclk);
      alert_mask_wr <= ~ot;
      overheat_mask_wr <= ot;
      mask_wdata <= v;
      @(posedge mclk);
      alert_mask_wr <= 1'b0;
      overheat_mask_wr <= 1'b0;
   endtask : wm

   // a full round of conversions fits well inside 200 cycles
   task automatic settle();
      repeat (200) @(posedge mclk);
      #1;
   endtask : settle

   // new temperatures, clear stale flags, then let one more round set them
   task automatic step(input logic [NCH-1:0][TEMP_W-1:0] v, input logic two);
      @(posedge mclk);
      temps <= v;
      settle();
      rd(two, 8'h00, 1'b0);
      settle();
   endtask : step

   task automatic results();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results

   // watchdog, about four and a half times the expected run
   initial
   begin
      repeat (30000) @(posedge mclk);
      num_errors++;
      $display("[FAIL] %0t run did not finish", $time);
      results();
   end

   initial
   begin
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      #1;
      chk(high_alert_flags, 8'h00);
      chk(overtemp_flags, 8'h00);
      chk(alert_mask_q, 8'h00);
      chk(overheat_mask_q, 8'h00);
      $display("test reset done");
      // one channel one degree above its limit, the rest released
      for (int i = 0; i < NCH; i++)
      begin
         t = {NCH{8'h2d}};
         t[i] = 8'h33;
         step(t, 1'b0);
         rd(1'b0, 8'h01 << i, 1'b1);
         settle();
         chk(high_alert_flags, 8'h01 << i);
         chk({7'h00, alert_output_oe}, 8'h01);
      end
      $display("test high alert done");
      step({NCH{8'h3d}}, 1'b1);
      rd(1'b1, 8'h39, 1'b1);
      chk({7'h00, overheat_shutdown_output_oe}, 8'h01);
      step({NCH{8'h38}}, 1'b1);
      rd(1'b1, 8'h39, 1'b1);
      step({NCH{8'h37}}, 1'b1);
      rd(1'b1, 8'h00, 1'b1);
      chk({7'h00, overheat_shutdown_output_oe}, 8'h00);
      $display("test overtemp done");
      step({NCH{8'h3d}}, 1'b1);
      wm(1'b0, 8'hff);
      wm(1'b1, 8'hff);
      repeat (3) @(posedge mclk);
      #1;
      chk(alert_mask_q, 8'h7f);
      chk(overheat_mask_q, 8'h39);
      chk({7'h00, alert_output_oe}, 8'h00);
      chk({7'h00, overheat_shutdown_output_oe}, 8'h00);
      chk(high_alert_flags, 8'h7f);
      // both strobes at once: only the high-alert flags are read and cleared
      @(posedge mclk);
      rd_status1 <= 1'b1;
      rd_status2 <= 1'b1;
      @(posedge mclk);
      rd_status1 <= 1'b0;
      rd_status2 <= 1'b0;
      #1;
      chk(rd_data, 8'h7f);
      chk(overtemp_flags, 8'h39);
      $display("test masks done");
      // remote 2 open and remote 5 tied to supply, slow engine
      @(posedge mclk);
      diode_open <= 6'h02;
      diode_at_supply <= 6'h10;
      delay <= 4'h9;
      wm(1'b0, 8'h12);
      wm(1'b1, 8'h10);
      step({NCH{8'h14}}, 1'b0);
      chk({2'b00, diode_fault}, 8'h12);
      rd(1'b0, 8'h00, 1'b1);
      chk({7'h00, alert_output_oe}, 8'h00);
      chk({7'h00, overheat_shutdown_output_oe}, 8'h00);
      bad = 0;
      repeat (200)
      begin
         @(posedge mclk);
         #1;
         if (conv_start === 1'b1 && (conv_channel === 3'h1 || conv_channel === 3'h4))
            bad++;
      end
      chk(8'(bad), 8'h00);
      $display("test diode fault done");
      results();
   end
endmodule : temp_threshold_status_flags_tb
`default_nettype wire
